/* hw/bspc_top.v */
// switching cycle sequencer and protection for a synchronous buck stage
//
// Behaviour
// - high-side switch turns on at each fixed-rate oscillator period start.
// - peak current reaching loop level ends high-side, low-side runs to period end.
// - valley over limit at period end skips high-side, low-side stays on.
// - overload beyond 512 cycles stops switching, restart after 16384 cycles.
// - sink limit turns low-side off at once, both off until next period.
// - feedback above 118% blocks high-side until below 104%.
// - over 165C stop; below 155C count 32768 cycles then restart.
// - boot undervoltage forces high-side off; otherwise 100% duty allowed.
// - pre-biased start keeps both switches off until soft-start exceeds feedback.
// - soft-start level ramps over about 5 ms after every start.
// - enable input starts operation; low enable stops switching, idle state.
// - input supply undervoltage disables the controller.
// - switching controller always runs forced continuous, never skips light-load periods.
// - regulation target is lower of soft-start level and fixed reference.
`timescale 1ns/1ps
`default_nettype none
`include "bspc_defines.vh"
module bspc_top (
    input wire clk,
    input wire rst,
    input wire enable_pin,
    input wire supply_ok,
    input wire peak_trip,
    input wire valley_over,
    input wire sink_over,
    input wire ovp_high,
    input wire ovp_low,
    input wire boot_ok,
    input wire thermal_hot,
    input wire thermal_cool,
    input wire ss_above_fb,
    input wire [3:0] addr,
    input wire [7:0] wdata,
    input wire wr,
    input wire rd,
    output reg [7:0] rdata,
    output reg hs_on,
    output reg ls_on,
    output reg [`BSPC_SS_W-1:0] reg_target,
    output reg active,
    output reg forced_continuous_mode
);
    // ****************************************
    // states
    // ****************************************
    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_PREBIAS = 3'h1;
    localparam [2:0] ST_RUN = 3'h2;
    localparam [2:0] ST_OC_WAIT = 3'h3;
    localparam [2:0] ST_TH_HOT = 3'h4;
    localparam [2:0] ST_TH_WAIT = 3'h5;

    // ****************************************
    // timing counts, cut to counter widths
    // ****************************************
    localparam [31:0] PERIOD_FULL = `BSPC_PERIOD_CYC;
    localparam [31:0] SS_STEP_FULL = `BSPC_SS_CYC / 1024;
    localparam [31:0] OC_WAIT_FULL = `BSPC_OC_WAIT_SW;
    localparam [31:0] OC_RESTART_FULL = `BSPC_OC_RESTART_SW;
    localparam [31:0] TH_RESTART_FULL = `BSPC_TH_RESTART_SW;
    localparam [15:0] PERIOD_DIV = PERIOD_FULL[15:0];
    localparam [15:0] SS_STEP_DIV = SS_STEP_FULL[15:0];
    localparam [9:0] OC_WAIT_N = OC_WAIT_FULL[9:0];
    localparam [15:0] OC_RESTART_N = OC_RESTART_FULL[15:0];
    localparam [15:0] TH_RESTART_N = TH_RESTART_FULL[15:0];

    // ****************************************
    // input synchronisers
    // ****************************************
    wire en_s;
    wire uv_ok_s;
    wire peak_s;
    wire valley_s;
    wire sink_s;
    wire ovh_s;
    wire ovl_s;
    wire boot_s;
    wire hot_s;
    wire cool_s;
    wire ssfb_s;
    wire [10:0] raw_in;
    wire [10:0] sync_out;
    assign raw_in = {enable_pin, supply_ok, peak_trip, valley_over, sink_over, ovp_high, ovp_low,
                     boot_ok, thermal_hot, thermal_cool, ss_above_fb};
    genvar gi;
    generate
        for (gi = 0; gi < 11; gi = gi + 1) begin : g_sync
            // flags from analog comparators are registered before any use
            bspc_sync u_sync (
                .clk(clk),
                .rst(rst),
                .d(raw_in[gi]),
                .q(sync_out[gi])
            );
        end
    endgenerate
    assign {en_s, uv_ok_s, peak_s, valley_s, sink_s, ovh_s, ovl_s, boot_s, hot_s, cool_s, ssfb_s} = sync_out;

    // ****************************************
    // period and soft-start tick dividers
    // ****************************************
    wire period_tick;
    wire ss_tick;
    wire run_enable;
    reg [7:0] ctrl;
    assign run_enable = en_s & uv_ok_s & ctrl[`BSPC_CTRL_SW_EN];
    // fixed-rate oscillator; keeps running so periods stay evenly spaced
    bspc_divider #(
        .W(16),
        .DIV(PERIOD_DIV)
    ) u_period (
        .clk(clk),
        .rst(rst),
        .run(1'b1),
        .tick(period_tick)
    );
    // one soft-start step per 1/1024 of the ramp time
    bspc_divider #(
        .W(16),
        .DIV(SS_STEP_DIV)
    ) u_ss (
        .clk(clk),
        .rst(rst),
        .run(1'b1),
        .tick(ss_tick)
    );

    // ****************************************
    // main sequencer
    // ****************************************
    reg [2:0] state;
    reg [2:0] next_state;
    reg [15:0] cyc_cnt;
    reg [9:0] oc_cnt;
    reg [`BSPC_SS_W-1:0] ss_level;
    reg ov_block;
    reg valley_skip;
    reg sink_cut;
    reg hs_done;
    reg overload;
    wire switching;
    assign switching = (state == ST_RUN);

    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (run_enable) begin
                    next_state = ST_PREBIAS;
                end
            end
            ST_PREBIAS: begin
                // pre-biased output: hold both off until ramp passes feedback
                if (ssfb_s) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (oc_cnt == OC_WAIT_N) begin
                    next_state = ST_OC_WAIT;
                end
            end
            ST_OC_WAIT: begin
                if (cyc_cnt == OC_RESTART_N) begin
                    next_state = ST_IDLE;
                end
            end
            ST_TH_HOT: begin
                if (cool_s) begin
                    next_state = ST_TH_WAIT;
                end
            end
            ST_TH_WAIT: begin
                if (hot_s) begin
                    next_state = ST_TH_HOT;
                end else if (cyc_cnt == TH_RESTART_N) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // shutdown takes priority over hiccup waits
        if (hot_s && state != ST_TH_HOT) begin
            next_state = ST_TH_HOT;
        end else if (!run_enable && state != ST_TH_HOT && state != ST_TH_WAIT) begin
            next_state = ST_IDLE;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            cyc_cnt <= 16'h0000;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                cyc_cnt <= 16'h0000;
            end else if (period_tick && cyc_cnt != 16'hFFFF) begin
                cyc_cnt <= cyc_cnt + 16'h0001;
            end
        end
    end

    // ****************************************
    // soft start and regulation target
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_level <= {`BSPC_SS_W{1'b0}};
        end else if (state == ST_IDLE || state == ST_OC_WAIT || state == ST_TH_HOT
                     || state == ST_TH_WAIT) begin
            ss_level <= {`BSPC_SS_W{1'b0}}; // hiccup restart begins from zero
        end else if (ss_tick && ss_level != `BSPC_SS_MAX) begin
            ss_level <= ss_level + 1'b1;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_target <= {`BSPC_SS_W{1'b0}};
        end else begin
            // lower of ramp and reference
            reg_target <= (ss_level < `BSPC_VREF_CODE) ? ss_level : `BSPC_VREF_CODE;
        end
    end

    // ****************************************
    // cycle-by-cycle switch control
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ov_block <= 1'b0;
        end else if (ovh_s) begin
            ov_block <= 1'b1;
        end else if (!ovl_s) begin
            ov_block <= 1'b0;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            valley_skip <= 1'b0;
            sink_cut <= 1'b0;
            hs_done <= 1'b0;
            overload <= 1'b0;
        end else if (!switching) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            valley_skip <= 1'b0;
            sink_cut <= 1'b0;
            hs_done <= 1'b0;
            overload <= 1'b0;
        end else if (period_tick) begin
            // no light-load skipping: every period starts a fresh cycle
            sink_cut <= 1'b0;
            overload <= valley_s;
            valley_skip <= valley_s;
            if (valley_s || ov_block || !boot_s) begin
                hs_on <= 1'b0;
                ls_on <= 1'b1;
                hs_done <= 1'b1;
            end else begin
                hs_on <= 1'b1;
                ls_on <= 1'b0;
                hs_done <= 1'b0;
            end
        end else if (hs_on && (peak_s || ov_block || !boot_s)) begin
            // peak trip, overshoot guard or boot undervoltage end the on time
            hs_on <= 1'b0;
            ls_on <= ~sink_cut;
            hs_done <= 1'b1;
            // a peak trip is normal regulation, so only valley periods count as overload
        end else if (ls_on && sink_s) begin
            ls_on <= 1'b0;
            sink_cut <= 1'b1;
        end else if (!hs_on && !ls_on && hs_done && !sink_cut) begin
            ls_on <= 1'b1;
        end
        // a period with good boot and no trip simply holds high side: 100% duty
    end

    // ****************************************
    // overload counter
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            oc_cnt <= 10'h000;
        end else if (!switching) begin
            oc_cnt <= 10'h000;
        end else if (period_tick) begin
            // long overloads only: one clean period clears the count
            if (overload) begin
                oc_cnt <= (oc_cnt == OC_WAIT_N) ? oc_cnt : oc_cnt + 10'h001;
            end else begin
                oc_cnt <= 10'h000;
            end
        end
    end

    // ****************************************
    // status outputs and register port
    // ****************************************
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            active <= 1'b0;
            forced_continuous_mode <= 1'b0;
        end else begin
            active <= switching;
            forced_continuous_mode <= switching;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl <= `BSPC_CTRL_RESET;
            rdata <= 8'h00;
        end else begin
            if (wr && addr == `BSPC_REG_CTRL) begin
                ctrl <= wdata;
            end
            if (rd) begin
                case (addr)
                    `BSPC_REG_CTRL: rdata <= ctrl;
                    `BSPC_REG_STATUS: rdata <= {ov_block, valley_skip, sink_cut, hs_on, ls_on, state};
                    `BSPC_REG_OCCNT: rdata <= oc_cnt[9:2];
                    `BSPC_REG_SS: rdata <= ss_level[9:2];
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/bspc_defines.vh */
// constants for the buck switch protection control block
`ifndef BSPC_DEFINES_VH
`define BSPC_DEFINES_VH
// clock and switching rate
`define BSPC_CLK_HZ 20000000
`define BSPC_FSW_HZ 350000
`define BSPC_PERIOD_CYC (`BSPC_CLK_HZ / `BSPC_FSW_HZ)
// hiccup and soft-start timing, in switching cycles or ms
`define BSPC_OC_WAIT_SW 512
`define BSPC_OC_RESTART_SW 16384
`define BSPC_TH_RESTART_SW 32768
`define BSPC_SS_MS 5
`define BSPC_SS_CYC ((`BSPC_CLK_HZ / 1000) * `BSPC_SS_MS)
// soft-start level resolution and full-scale code
`define BSPC_SS_W 10
`define BSPC_SS_MAX 10'h3FF
// regulation reference, millivolts, and code on the soft-start scale
`define BSPC_VREF_MV 596
`define BSPC_VREF_CODE 10'h3FF
// register offsets
`define BSPC_REG_CTRL 4'h0
`define BSPC_REG_STATUS 4'h1
`define BSPC_REG_OCCNT 4'h2
`define BSPC_REG_SS 4'h3
// control field positions and reset value
`define BSPC_CTRL_SW_EN 0
`define BSPC_CTRL_RESET 8'h01
// main states
`define BSPC_ST_W 3
`endif

/* hw/bspc_sync.v */
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bspc_sync (
    input wire clk,
    input wire rst,
    input wire d,
    output reg q
);
    reg s1;
    reg s2;
    reg s3;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
            q <= 1'b0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
            // change only once second and third agree
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule
`default_nettype wire

/* hw/bspc_divider.v */
// counter that emits a one-cycle pulse every div cycles
`timescale 1ns/1ps
`default_nettype none
module bspc_divider #(
    parameter W = 16,
    parameter [W-1:0] DIV = 16'h0001
) (
    input wire clk,
    input wire rst,
    input wire run,
    output reg tick
);
    reg [W-1:0] cnt;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= {W{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            cnt <= {W{1'b0}};
            tick <= 1'b0;
        end else if (cnt == DIV - 1'b1) begin
            cnt <= {W{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt <= cnt + 1'b1;
            tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verification/bspc_checker.sv */
// port assertions for the buck switch sequencer
`timescale 1ns/1ps
`default_nettype none
module bspc_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable_pin,
    input wire logic sink_over,
    input wire logic ovp_high,
    input wire logic ovp_low,
    input wire logic boot_ok,
    input wire logic hs_on,
    input wire logic ls_on,
    input wire logic active,
    input wire logic forced_continuous_mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ****
    // gate sequencing
    // ****
    // five to seven clocks cover the input sync and the output registers
    sequence s_hs_end;
        !sink_over [*5] ##0 ($fell(hs_on) && active) ##1 active;
    endsequence
    sequence s_ovp_release;
        ovp_high ##1 (ovp_low && !ovp_high) [*6];
    endsequence
    a_no_overlap: assert property (!(hs_on && ls_on)) else $error("both on");
    a_ls_follows: assert property (s_hs_end |-> ##[0:1] ls_on) else $error("low side late");
    a_sink_cut: assert property (sink_over [*6] ##0 ls_on |-> ##[1:2] !ls_on) else $error("sink not cut");
    a_ovp_block: assert property (ovp_high [*7] |-> !hs_on) else $error("high side in ovp");
    a_ovp_hold: assert property (s_ovp_release |-> !hs_on) else $error("ovp freed early");
    a_boot_cut: assert property (!boot_ok [*6] |-> !hs_on) else $error("low boot");
    a_enable_stop: assert property (!enable_pin [*7] |-> !hs_on && !ls_on && !active) else $error("runs off");
    a_forced_continuous_mode_run: assert property (active |-> forced_continuous_mode) else $error("mode low");
endmodule
bind bspc_top bspc_checker i_chk (
    .clk(clk), .rst(rst), .enable_pin(enable_pin), .sink_over(sink_over), .ovp_high(ovp_high),
    .ovp_low(ovp_low), .boot_ok(boot_ok), .hs_on(hs_on), .ls_on(ls_on), .active(active),
    .forced_continuous_mode(forced_continuous_mode)
);
`default_nettype wire

/* verification/bspc_power_stage.sv */
// behavioural power stage: inductor ramp and pre-charged output
`timescale 1ns/1ps
`default_nettype none
module bspc_power_stage (
    input wire logic clk,
    input wire logic hs_on,
    input wire logic [7:0] load,
    input wire logic [9:0] sense_level,
    input wire logic [9:0] reg_target,
    output logic peak_trip,
    output logic ss_above_fb
);
    logic [7:0] ramp = 8'h00;
    // ****
    // inductor current and sense comparators
    // ****
    always @(posedge clk) begin
        ramp <= !hs_on ? 8'h00 : ramp + {7'h00, ramp != 8'hFF};
    end
    // load of zero never trips, which gives full duty
    assign peak_trip = hs_on && load != 8'h00 && ramp >= load;
    // a charged output reads high until the ramp passes it
    assign ss_above_fb = reg_target > sense_level;
endmodule
`default_nettype wire

/* verification/test_bspc_top.sv */
// self-checking bench for the buck switch sequencer
`timescale 1ns/1ps
`default_nettype none
`include "bspc_defines.vh"
module test_bspc_top;
    localparam int P = `BSPC_PERIOD_CYC;
    localparam int STEP = `BSPC_SS_CYC / `BSPC_SS_MAX;
    logic clk = 1'b0, rst = 1'b1, enable_pin = 1'b1, supply_ok = 1'b1, boot_ok = 1'b1, thermal_cool = 1'b1;
    logic valley_over = 1'b0, sink_over = 1'b0, ovp_high = 1'b0, ovp_low = 1'b0, thermal_hot = 1'b0;
    logic wr = 1'b0, rd = 1'b0, hs_on, ls_on, active, fc_mode, peak_trip, ss_above_fb;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, load = 8'h0A, rdata;
    logic [9:0] sense_level = 10'h3FF, reg_target;
    int num_errors = 0, total_checks = 0;
    // load, {valley, ovp, boot low, sink}, {0, one turn-on, high side most, low side most}
    logic [15:0] rows [6] = '{16'h0A05, 16'h0002, 16'h0A81, 16'h0A41, 16'h0A21, 16'h0A14};
    always #25 clk = ~clk;
    bspc_top i_dut (
        .clk(clk), .rst(rst), .enable_pin(enable_pin), .supply_ok(supply_ok), .peak_trip(peak_trip),
        .valley_over(valley_over), .sink_over(sink_over), .ovp_high(ovp_high), .ovp_low(ovp_low),
        .boot_ok(boot_ok), .thermal_hot(thermal_hot), .thermal_cool(thermal_cool), .ss_above_fb(ss_above_fb),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .hs_on(hs_on), .ls_on(ls_on),
        .reg_target(reg_target), .active(active), .forced_continuous_mode(fc_mode)
    );
    bspc_power_stage i_stage (
        .clk(clk), .hs_on(hs_on), .load(load), .sense_level(sense_level), .reg_target(reg_target),
        .peak_trip(peak_trip), .ss_above_fb(ss_above_fb)
    );
    // ****
    // helpers
    // ****
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h", $time, what, got);
        end
    endtask
    // samples one step after the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        @(posedge clk);
        {wr, rd} <= 2'b00;
        #1;
        q = rdata;
    endtask
    task automatic wait_active(input logic lvl);
        for (int i = 0; i < 400 && active !== lvl; i++) cyc(1);
        chk(10'(active), 10'(lvl), "active");
        if (active !== lvl) complete_run();
    endtask
    task automatic measure(output logic [3:0] r);
        int h;
        int l;
        int n;
        logic p;
        h = 0;
        l = 0;
        n = 0;
        repeat (P) begin
            p = hs_on;
            cyc(1);
            n += (hs_on === 1'b1 && p === 1'b0);
            h += (hs_on === 1'b1);
            l += (ls_on === 1'b1);
        end
        r = {1'b0, n == 1, h > P / 2, l > P / 2};
    endtask
    // ****
    // main sequence
    // ****
    initial begin
        logic [15:0] r;
        logic [7:0] rv;
        logic [3:0] res;
        cyc(10);
        rst <= 1'b0;
        cyc(300);
        chk(10'({hs_on, ls_on, active}), 10'h000, "prebias");
        sense_level <= 10'h000;
        wait_active(1'b1);
        chk(10'(fc_mode), 10'h001, "mode");
        for (int i = 0; i < 2000 && reg_target !== 10'h00A; i++) cyc(1);
        chk(reg_target, 10'h00A, "ramp start");
        if (reg_target !== 10'h00A) complete_run();
        cyc(5 * STEP + 10);
        chk(reg_target, 10'h00F, "ramp");
        bus(1'b0, `BSPC_REG_OCCNT, 8'h00, rv);
        chk(10'(rv), 10'h000, "no overload");
        $display("start done");
        foreach (rows[i]) begin
            r = rows[i];
            load <= r[15:8];
            {valley_over, ovp_high, ovp_low, boot_ok, sink_over} <= {r[7], r[6], r[6], !r[5], r[4]};
            cyc(2 * P);
            measure(res);
            chk(10'(res), 10'(r[3:0]), "row");
            $display("row %0d done", i);
        end
        {load, sink_over, ovp_high, ovp_low} <= {8'h0A, 3'b011};
        cyc(P);
        ovp_high <= 1'b0;
        cyc(P);
        measure(res);
        chk(10'(res[2]), 10'h000, "ovp hold");
        ovp_low <= 1'b0;
        cyc(P);
        measure(res);
        chk(10'(res[2]), 10'h001, "ovp free");
        bus(1'b0, `BSPC_REG_STATUS, 8'h00, rv);
        chk(10'(rv[2:0]), 10'h002, "status");
        bus(1'b0, 4'hF, 8'h00, rv);
        chk(10'(rv), 10'h000, "unmapped");
        bus(1'b1, `BSPC_REG_CTRL, 8'h00, rv);
        wait_active(1'b0);
        bus(1'b0, `BSPC_REG_CTRL, 8'h00, rv);
        chk(10'(rv), 10'h000, "ctrl");
        bus(1'b1, `BSPC_REG_CTRL, 8'h01, rv);
        wait_active(1'b1);
        $display("bus done");
        for (int k = 0; k < 2; k++) begin
            {enable_pin, supply_ok} <= k[0] ? 2'b10 : 2'b01;
            cyc(10);
            chk(10'({hs_on, ls_on, active}), 10'h000, "stop");
            chk(reg_target, 10'h000, "ramp clear");
            {enable_pin, supply_ok} <= 2'b11;
            wait_active(1'b1);
        end
        {thermal_hot, thermal_cool} <= 2'b10;
        cyc(10);
        chk(10'({hs_on, ls_on, active}), 10'h000, "hot");
        {thermal_hot, thermal_cool} <= 2'b01;
        cyc(2000);
        chk(10'(active), 10'h000, "hiccup");
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        wait_active(1'b1);
        $display("thermal done");
        // the long restart wait is not run: only entry into hiccup is seen
        valley_over <= 1'b1;
        cyc(500 * P);
        chk(10'(active), 10'h001, "overload early");
        cyc(20 * P);
        chk(10'({hs_on, ls_on, active}), 10'h000, "overload stop");
        $display("overload done");
        complete_run();
    end
endmodule
`default_nettype wire
